// *** logic/hbdp_pkg.sv ***
package hbdp_pkg;
    localparam int  CLK_PERIOD_NS = 100;
    localparam int  BUSY_MAX_NS   = 4000;
    // Longest wait rounds down
    localparam int  BUSY_MAX_CYC  = BUSY_MAX_NS / CLK_PERIOD_NS;
    localparam int  DATA_W        = 16;
    localparam int  SEL_W         = 4;
    localparam int  FIFO_DEPTH    = 8;
    localparam logic DIR_OUT      = 1'b1;
    localparam logic DIR_IN       = 1'b0;
    localparam logic [DATA_W-1:0] VEC_RESET = 16'h0000;
endpackage

// *** logic/hbdp_if.sv ***
`timescale 1ns/1ps
// Host-side pins; the two-way bus is resolved here from the enables
interface hbdp_if;
    logic                       host_read_strobe_n;
    logic                       host_write_strobe_n;
    logic                       port_select_n;
    logic                       irq_acknowledge_n;
    logic                       select_latch_strobe;
    logic                       upper_byte_enable_n;
    logic [hbdp_pkg::SEL_W-1:0] reg_select;
    logic                       host_ready_n;
    logic                       host_ready_oe;
    logic                       buffer_enable_n;
    logic                       buffer_direction;
    logic                       hold_request;
    logic                       hold_grant;
    logic                       bus_busy_n;
    logic                       bus_owned_n;
    logic [15:0]                dev_ad;
    logic                       dev_ad_oe;
    logic [15:0]                host_ad;
    logic                       host_ad_oe;
    logic [1:0]                 dev_par;
    logic [1:0]                 host_par;
    logic [15:0]                ad_bus;
    logic [1:0]                 parity;

    // Wire level: whoever enables drives, otherwise float high
    assign ad_bus = dev_ad_oe ? dev_ad : (host_ad_oe ? host_ad : 16'hffff);
    assign parity = dev_ad_oe ? dev_par : (host_ad_oe ? host_par : 2'h3);

    modport dev (
        input  host_read_strobe_n, host_write_strobe_n, port_select_n, irq_acknowledge_n,
        input  select_latch_strobe, upper_byte_enable_n, reg_select, hold_grant,
        input  bus_busy_n, ad_bus, parity,
        output host_ready_n, host_ready_oe, buffer_enable_n, buffer_direction,
        output hold_request, bus_owned_n, dev_ad, dev_ad_oe, dev_par
    );
    modport host (
        output host_read_strobe_n, host_write_strobe_n, port_select_n, irq_acknowledge_n,
        output select_latch_strobe, upper_byte_enable_n, reg_select, hold_grant,
        output bus_busy_n, host_ad, host_ad_oe, host_par,
        input  host_ready_n, host_ready_oe, buffer_enable_n, buffer_direction,
        input  hold_request, bus_owned_n, ad_bus, parity
    );
endinterface

// *** logic/hbdp_fifo.sv ***
`timescale 1ns/1ps
// Small flip-flop FIFO with valid/ready on both sides
module hbdp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk_i,
    input  wire logic             nrst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem_r[rd_r];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Storage
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_r[wr_r] <= in_data_i;
        end
    end

    // Pointers wrap at depth, so depth need not be a power of two
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// *** logic/hbdp_dev.sv ***
`timescale 1ns/1ps
// Device end: register access slave, acknowledge cycle, DMA read start
module hbdp_dev #(
    parameter int BUSY_CYC = hbdp_pkg::BUSY_MAX_CYC,
    parameter int FDEPTH   = hbdp_pkg::FIFO_DEPTH
) (
    input  wire logic                       sys_clk_i,
    input  wire logic                       nrst_i,
    hbdp_if.dev                             pins,
    input  wire logic                       byte_mode_i,
    input  wire logic                       dma_req_i,
    input  wire logic [31:0]                rd_regs_i,
    input  wire logic [15:0]                irq_vector_i,
    input  wire logic                       reg_busy_i,
    output logic      [hbdp_pkg::SEL_W-1:0] wr_sel_o,
    output logic      [15:0]                wr_data_o,
    output logic                            wr_valid_o,
    input  wire logic                       wr_ready_i,
    output logic      [17:0]                dma_data_o,
    output logic                            dma_valid_o,
    input  wire logic                       dma_ready_i,
    output logic                            dma_done_o
);
    typedef enum {S_IDLE, S_DIR, S_BUF, S_WAIT, S_RDY, S_END} hbdp_acc_t;
    typedef enum {D_IDLE, D_REQ, D_I1, D_I2, D_TX, D_T1, D_T2, D_T3, D_T4} hbdp_dma_t;

    hbdp_acc_t        acc_r;
    hbdp_dma_t        dma_r;
    logic [2:0]       s1_r;
    logic [2:0]       s2_r;
    logic [1:0]       g1_r;
    logic [1:0]       g2_r;
    logic             wr_cyc_r;
    logic             ack_cyc_r;
    logic             ack_first_r;
    logic [3:0]       sel_r;
    logic [3:0]       sel_lat_r;
    logic             ube_lat_r;
    logic [15:0]      wdata_r;
    logic [15:0]      rdata_r;
    logic [12:0]      wait_r;
    logic             owned;
    logic             rd_s;
    logic             wr_s;
    logic             ack_s;
    logic             strobes_idle;
    logic             fifo_rdy;
    logic             fifo_vld;
    logic [17:0]      fifo_dat;

    // Pick the addressed half-word of read data
    function automatic logic [15:0] reg_word(input logic [31:0] r, input logic [3:0] s);
        reg_word = s[0] ? r[31:16] : r[15:0];
    endfunction

    assign owned = (dma_r == D_I2) || (dma_r == D_TX) || (dma_r == D_T1)
                || (dma_r == D_T2) || (dma_r == D_T3) || (dma_r == D_T4);

    ////////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers; first stage is read only by the second
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_r <= 3'h7;
            s2_r <= 3'h7;
            g1_r <= 2'h1;
            g2_r <= 2'h1;
        end else begin
            // Select folded in at stage one; ignored while owned
            s1_r <= {pins.host_read_strobe_n | (pins.port_select_n | owned),
                     pins.host_write_strobe_n | (pins.port_select_n | owned),
                     pins.irq_acknowledge_n};
            s2_r <= s1_r;
            g1_r <= {pins.hold_grant, pins.bus_busy_n};
            g2_r <= g1_r;
        end
    end
    assign rd_s         = !s2_r[2];
    assign wr_s         = !s2_r[1];
    assign ack_s        = !s2_r[0];
    assign strobes_idle = (s2_r == 3'h7);

    // Selects registered while the latch strobe is high; when it is tied high, they follow the pins one clock later
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sel_lat_r <= '0;
            ube_lat_r <= 1'b1;
        end else if (pins.select_latch_strobe) begin
            sel_lat_r <= pins.reg_select;
            ube_lat_r <= pins.upper_byte_enable_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Access sequencer: whole clock steps for direction, buffer and ready
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acc_r       <= S_IDLE;
            wr_cyc_r    <= 1'b0;
            ack_cyc_r   <= 1'b0;
            ack_first_r <= 1'b1;
            sel_r       <= '0;
            wdata_r     <= '0;
            rdata_r     <= hbdp_pkg::VEC_RESET;
            wait_r      <= '0;
        end else begin
            case (acc_r)
                S_IDLE: begin
                    if (ack_s) begin
                        // First pulse only arms; second one returns data
                        if (ack_first_r) begin
                            ack_first_r <= 1'b0;
                            acc_r       <= S_END;
                        end else begin
                            ack_first_r <= 1'b1;
                            ack_cyc_r   <= 1'b1;
                            wr_cyc_r    <= 1'b0;
                            rdata_r     <= irq_vector_i;
                            acc_r       <= S_BUF;
                        end
                    end else if (wr_s) begin
                        wr_cyc_r  <= 1'b1;
                        ack_cyc_r <= 1'b0;
                        sel_r     <= sel_lat_r;
                        acc_r     <= S_DIR;
                    end else if (rd_s) begin
                        wr_cyc_r  <= 1'b0;
                        ack_cyc_r <= 1'b0;
                        sel_r     <= sel_lat_r;
                        rdata_r   <= reg_word(rd_regs_i, sel_lat_r);
                        acc_r     <= S_BUF;
                    end
                end
                S_DIR: acc_r <= S_BUF;
                S_BUF: begin
                    wait_r <= '0;
                    if (wr_cyc_r) begin
                        // Capture before the buffer can go inactive
                        wdata_r <= byte_mode_i ? {8'h00, pins.ad_bus[7:0]}
                                               : pins.ad_bus;
                    end
                    acc_r <= S_WAIT;
                end
                S_WAIT: begin
                    // Busy target stalls ready on writes only, capped near the longest wait
                    wait_r <= wait_r + 13'h0001;
                    if (!(wr_cyc_r && (reg_busy_i || !wr_ready_i))
                        || wait_r >= 13'(BUSY_CYC - 3)) begin
                        acc_r <= S_RDY;
                    end
                end
                S_RDY: begin
                    if (strobes_idle) begin
                        acc_r <= S_END;
                    end
                end
                S_END: begin
                    if (strobes_idle) begin
                        acc_r <= S_IDLE;
                    end
                end
                default: acc_r <= S_IDLE;
            endcase
        end
    end

    // Write hands off to the register side when ready is given
    assign wr_sel_o   = sel_r;
    assign wr_data_o  = wdata_r;
    assign wr_valid_o = (acc_r == S_WAIT) && wr_cyc_r && !reg_busy_i && wr_ready_i;

    ////////////////////////////////////////////////////////////////////////////////
    // DMA arbitration and read start; FIFO back-pressure delays the request
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dma_r <= D_IDLE;
        end else begin
            case (dma_r)
                D_IDLE: if (dma_req_i && fifo_rdy && acc_r == S_IDLE) dma_r <= D_REQ;
                D_REQ:  if (g2_r[1] && g2_r[0]) dma_r <= D_I1;
                D_I1:   dma_r <= D_I2;
                D_I2:   dma_r <= D_TX;
                D_TX:   dma_r <= D_T1;
                D_T1:   dma_r <= D_T2;
                D_T2:   dma_r <= D_T3;
                D_T3:   dma_r <= D_T4;
                D_T4:   dma_r <= D_IDLE;
                default: dma_r <= D_IDLE;
            endcase
        end
    end

    hbdp_fifo #(.WIDTH(18), .DEPTH(FDEPTH)) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .nrst_i      (nrst_i),
        .in_data_i   ({pins.parity, pins.ad_bus}),
        .in_valid_i  (dma_r == D_T3),
        .in_ready_o  (fifo_rdy),
        .out_data_o  (fifo_dat),
        .out_valid_o (fifo_vld),
        .out_ready_i (dma_ready_i)
    );
    assign dma_data_o  = fifo_dat;
    assign dma_valid_o = fifo_vld;
    assign dma_done_o  = (dma_r == D_T4);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drive
    assign pins.hold_request     = (dma_r != D_IDLE);
    assign pins.bus_owned_n      = !owned;
    assign pins.host_ready_n     = !(acc_r == S_RDY);
    // Ready is driven high for the end cycle before it is let go
    assign pins.host_ready_oe    = (acc_r == S_RDY) || (acc_r == S_END);
    assign pins.buffer_enable_n  = !(acc_r == S_BUF || acc_r == S_WAIT || acc_r == S_RDY
                                   || owned);
    assign pins.buffer_direction = (owned || (acc_r != S_IDLE && wr_cyc_r))
                                   ? hbdp_pkg::DIR_IN : hbdp_pkg::DIR_OUT;
    // Upper byte left as-is in byte mode; host discards it
    assign pins.dev_ad           = rdata_r;
    assign pins.dev_ad_oe        = !wr_cyc_r && (acc_r == S_WAIT || acc_r == S_RDY);
    assign pins.dev_par          = {~^rdata_r[15:8], ~^rdata_r[7:0]};
endmodule

// *** logic/hbdp_host.sv ***
`timescale 1ns/1ps
// Host end: drives register accesses and acknowledge cycles, grants the bus
module hbdp_host (
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    hbdp_if.host             pins,
    input  wire logic        req_i,
    input  wire logic [1:0]  kind_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [15:0] wdata_i,
    output logic             busy_o,
    output logic             done_o,
    output logic      [15:0] rdata_o,
    input  wire logic        grant_en_i
);
    typedef enum {H_IDLE, H_ACT, H_GAP, H_ACK1, H_ACKG} hbdp_host_t;
    hbdp_host_t  st_r;
    logic [1:0]  kind_r;
    logic [3:0]  sel_r;
    logic [15:0] wd_r;
    logic        done_r;
    logic [15:0] rd_r;
    logic        rdy1_r;
    logic        rdy2_r;

    // Ready is asynchronous to us, so synchronise it
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdy1_r <= 1'b1;
            rdy2_r <= 1'b1;
        end else begin
            rdy1_r <= pins.host_ready_oe ? pins.host_ready_n : 1'b1;
            rdy2_r <= rdy1_r;
        end
    end

    // Kind 0 read, 1 write, 2 interrupt acknowledge
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r   <= H_IDLE;
            kind_r <= '0;
            sel_r  <= '0;
            wd_r   <= '0;
            done_r <= 1'b0;
            rd_r   <= '0;
        end else begin
            done_r <= 1'b0;
            case (st_r)
                H_IDLE: if (req_i) begin
                    kind_r <= kind_i;
                    sel_r  <= sel_i;
                    wd_r   <= wdata_i;
                    st_r   <= (kind_i == 2'h2) ? H_ACK1 : H_ACT;
                end
                H_ACK1: st_r <= H_ACKG; // First pulse one clock low
                H_ACKG: st_r <= H_ACT;
                H_ACT: if (!rdy2_r) begin
                    rd_r   <= pins.ad_bus;
                    done_r <= 1'b1;
                    st_r   <= H_GAP;
                end
                H_GAP: if (pins.host_ready_n || !pins.host_ready_oe) st_r <= H_IDLE;
                default: st_r <= H_IDLE;
            endcase
        end
    end

    assign busy_o  = (st_r != H_IDLE);
    assign done_o  = done_r;
    assign rdata_o = rd_r;

    // Selects held through the cycle with the latch strobe tied high
    assign pins.select_latch_strobe = 1'b1;
    assign pins.reg_select          = sel_r;
    assign pins.upper_byte_enable_n = 1'b0;
    // Select and acknowledge never active together
    assign pins.port_select_n       = !(st_r == H_ACT && kind_r != 2'h2);
    assign pins.host_read_strobe_n  = !(st_r == H_ACT && kind_r == 2'h0);
    assign pins.host_write_strobe_n = !(st_r == H_ACT && kind_r == 2'h1);
    assign pins.irq_acknowledge_n   = !(st_r == H_ACK1 || (st_r == H_ACT && kind_r == 2'h2));
    assign pins.host_ad             = wd_r;
    assign pins.host_ad_oe          = (st_r == H_ACT && kind_r == 2'h1);
    assign pins.host_par            = {~^wd_r[15:8], ~^wd_r[7:0]};
    // Grant follows request while grant_en_i is set; bus never busy from this side
    assign pins.hold_grant          = grant_en_i && pins.hold_request;
    assign pins.bus_busy_n          = 1'b1;
endmodule

// *** testbench/hbdp_props.sv ***
`timescale 1ns/1ps
////////////////////////////////////////
// Watches the pins between the two ends; one clock domain only
module hbdp_props (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire logic port_select_n,
    input wire logic irq_acknowledge_n,
    input wire logic host_ready_n,
    input wire logic host_ready_oe,
    input wire logic buffer_enable_n,
    input wire logic buffer_direction,
    input wire logic hold_request,
    input wire logic hold_grant,
    input wire logic bus_owned_n
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    ////////////////////////////////////////
    // Host side manners
    property p_ack_apart; !irq_acknowledge_n |-> port_select_n && host_read_strobe_n
        && host_write_strobe_n; endproperty
    a_ack_apart: assert property (p_ack_apart) else $error("ack overlaps access");
    // Any strobe falling needs a whole clock with all strobes high before it
    property p_idle_gap; ($fell(host_read_strobe_n) || $fell(host_write_strobe_n)
        || $fell(irq_acknowledge_n)) |-> $past(host_read_strobe_n)
        && $past(host_write_strobe_n) && $past(irq_acknowledge_n); endproperty
    a_idle_gap: assert property (p_idle_gap) else $error("strobe gap too short");

    ////////////////////////////////////////
    // Register access sequencing on the device side
    property p_wr_order; $fell(buffer_enable_n) && !host_write_strobe_n
        |-> $past(buffer_direction) == hbdp_pkg::DIR_IN; endproperty
    a_wr_order: assert property (p_wr_order) else $error("buffer before dir");
    property p_rdy_buf; $fell(host_ready_n) && host_ready_oe |-> !buffer_enable_n
        && $past(buffer_enable_n) == 1'b0; endproperty
    a_rdy_buf: assert property (p_rdy_buf) else $error("ready before buffer");
    property p_rd_buf; $fell(host_read_strobe_n) && !port_select_n && bus_owned_n
        |-> ##[1:5] !buffer_enable_n; endproperty
    a_rd_buf: assert property (p_rd_buf) else $error("read buffer late");
    property p_rdy_release; $fell(host_ready_oe) |-> $past(host_ready_n); endproperty
    a_rdy_release: assert property (p_rdy_release) else $error("ready freed low");
    // Bound of four covers two sync flops, the high drive and the release
    property p_rdy_drop; host_ready_oe && host_read_strobe_n && host_write_strobe_n
        && irq_acknowledge_n |-> ##[0:4] !host_ready_oe; endproperty
    a_rdy_drop: assert property (p_rdy_drop) else $error("ready held too long");

    ////////////////////////////////////////
    // Bus acquisition for DMA
    property p_hold_first; $rose(hold_request) |-> bus_owned_n; endproperty
    a_hold_first: assert property (p_hold_first) else $error("owned before req");
    property p_own_grant; $fell(bus_owned_n) |-> hold_request && hold_grant; endproperty
    a_own_grant: assert property (p_own_grant) else $error("owned without grant");
    property p_own_dir; !bus_owned_n |-> buffer_direction == hbdp_pkg::DIR_IN; endproperty
    a_own_dir: assert property (p_own_dir) else $error("owned with outbound dir");
    property p_own_quiet; !bus_owned_n |-> !host_ready_oe; endproperty
    a_own_quiet: assert property (p_own_quiet) else $error("access while owned");
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
////////////////////////////////////////
// Both ends face each other; the bench drives their user sides
module tb_top;
    logic        sys_clk;
    logic        nrst;
    logic        h_req;
    logic [1:0]  h_kind;
    logic [3:0]  h_sel;
    logic [15:0] h_wdata;
    logic        grant_en;
    logic        h_busy;
    logic        h_done;
    logic [15:0] h_rdata;
    logic        byte_mode;
    logic        dma_req;
    logic [31:0] rd_regs;
    logic [15:0] irq_vec;
    logic        reg_busy;
    logic [3:0]  wr_sel;
    logic [15:0] wr_data;
    logic        wr_valid;
    logic        wr_ready;
    logic [17:0] dma_data;
    logic        dma_valid;
    logic        dma_ready;
    logic        dma_done;
    logic [15:0] wr_seen;
    logic [3:0]  sel_seen;
    logic [15:0] wire_q;
    logic        own_seen;
    int          ack_cnt;
    int          op_cyc;
    int          t_free;
    int          error_cnt;
    int          n_compared;
    int          k;

    hbdp_if bus ();

    // Short busy cap keeps the stalled write quick
    hbdp_dev #(.BUSY_CYC(8), .FDEPTH(8)) i_hbdp_dev (
        .sys_clk_i(sys_clk), .nrst_i(nrst), .pins(bus), .byte_mode_i(byte_mode),
        .dma_req_i(dma_req), .rd_regs_i(rd_regs), .irq_vector_i(irq_vec),
        .reg_busy_i(reg_busy), .wr_sel_o(wr_sel), .wr_data_o(wr_data),
        .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .dma_data_o(dma_data),
        .dma_valid_o(dma_valid), .dma_ready_i(dma_ready), .dma_done_o(dma_done));
    hbdp_host i_hbdp_host (
        .sys_clk_i(sys_clk), .nrst_i(nrst), .pins(bus), .req_i(h_req), .kind_i(h_kind),
        .sel_i(h_sel), .wdata_i(h_wdata), .busy_o(h_busy), .done_o(h_done),
        .rdata_o(h_rdata), .grant_en_i(grant_en));
    hbdp_props i_hbdp_props (
        .sys_clk_i(sys_clk), .nrst_i(nrst), .host_read_strobe_n(bus.host_read_strobe_n),
        .host_write_strobe_n(bus.host_write_strobe_n), .port_select_n(bus.port_select_n),
        .irq_acknowledge_n(bus.irq_acknowledge_n), .host_ready_n(bus.host_ready_n),
        .host_ready_oe(bus.host_ready_oe), .buffer_enable_n(bus.buffer_enable_n),
        .buffer_direction(bus.buffer_direction), .hold_request(bus.hold_request),
        .hold_grant(bus.hold_grant), .bus_owned_n(bus.bus_owned_n));

    ////////////////////////////////////////
    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Wire monitors: accepted writes, data under ready, ownership
    always @(posedge sys_clk) begin
        if (wr_valid && wr_ready) begin
            wr_seen <= wr_data;
            sel_seen <= wr_sel;
        end
        if (bus.host_ready_oe && !bus.host_ready_n) wire_q <= bus.ad_bus;
        if (!bus.bus_owned_n) own_seen <= 1'b1;
    end

    // Counts acknowledge pulses on the wire
    always @(negedge bus.irq_acknowledge_n) ack_cnt++;

    ////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // A bound that runs out is a failure, not a hang
    task automatic fail_wait;
        check("wait_bound", 1'b1, 1'b0);
        stop_test();
    endtask

    // One host request; raised once the host end is idle, dropped once it is taken
    task automatic host_op(input logic [1:0] kd, input logic [3:0] s, input logic [15:0] d);
        int i;
        for (i = 0; i < 50 && h_busy !== 1'b0; i++) begin
            @(posedge sys_clk);
            #10;
        end
        if (i == 50) fail_wait();
        h_req = 1'b1;
        h_kind = kd;
        h_sel = s;
        h_wdata = d;
        // A request raised during the end gap would be lost, so it stands until taken
        for (i = 0; i < 50 && h_busy !== 1'b1; i++) begin
            @(posedge sys_clk);
            #10;
        end
        if (i == 50) fail_wait();
        h_req = 1'b0;
        for (i = 0; i < 200; i++) begin
            @(posedge sys_clk);
            #10;
            if (h_done === 1'b1) break;
        end
        if (i == 200) fail_wait();
        op_cyc = i;
    endtask

    // One DMA read; gap holds the grant back that many cycles
    task automatic dma_run(input logic go, input int gap);
        int i;
        own_seen = 1'b0;
        @(posedge sys_clk);
        #10;
        dma_req = 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            #10;
            if (bus.hold_request === 1'b1) break;
        end
        dma_req = 1'b0;
        check("dma_start", i < 20, go);
        if (go) begin
            if (gap > 0) begin
                repeat (gap) @(posedge sys_clk);
                #10;
                check("own_early", own_seen, 1'b0);
            end
            grant_en = 1'b1;
            for (i = 0; i < 60; i++) begin
                @(posedge sys_clk);
                #10;
                if (dma_done === 1'b1) break;
            end
            if (i == 60) fail_wait();
            check("own_seen", own_seen, 1'b1);
        end
    endtask

    ////////////////////////////////////////
    // Main sequence
    initial begin
        error_cnt = 0;
        n_compared = 0;
        nrst = 1'b0;
        h_req = 1'b0;
        h_kind = 2'h0;
        h_sel = 4'h0;
        h_wdata = 16'h0000;
        grant_en = 1'b1;
        byte_mode = 1'b0;
        dma_req = 1'b0;
        rd_regs = 32'ha5c3_1e7f;
        irq_vec = 16'h5a3c;
        reg_busy = 1'b0;
        wr_ready = 1'b1;
        dma_ready = 1'b0;
        ack_cnt = 0;
        repeat (12) @(posedge sys_clk);
        #10;
        nrst = 1'b1;
        // Back-to-back reads, both halves, checked at the port and on the wire
        for (k = 0; k < 4; k++) begin
            host_op(2'h0, 4'(k), 16'h0000);
            check("rd_data", h_rdata, k[0] ? rd_regs[31:16] : rd_regs[15:0]);
            check("rd_wire", wire_q, k[0] ? rd_regs[31:16] : rd_regs[15:0]);
            check("rd_gap", op_cyc <= 40, 1'b1);
        end
        host_op(2'h1, 4'h5, 16'hc3a5);
        t_free = op_cyc;
        check("wr_data", wr_seen, 16'hc3a5);
        check("wr_sel", sel_seen, 4'h5);
        // A busy target stretches the write, but only up to the cap
        reg_busy = 1'b1;
        host_op(2'h1, 4'h2, 16'h0f0f);
        reg_busy = 1'b0;
        check("busy_wait", (op_cyc > t_free) && (op_cyc <= t_free + 8), 1'b1);
        // A write that runs into the cap is not handed on
        check("busy_data", wr_seen, 16'hc3a5);
        byte_mode = 1'b1;
        host_op(2'h1, 4'h3, 16'h7e81);
        check("wr_byte", wr_seen, 16'h0081);
        host_op(2'h0, 4'h1, 16'h0000);
        check("rd_byte", h_rdata[7:0], rd_regs[23:16]);
        byte_mode = 1'b0;
        ack_cnt = 0;
        host_op(2'h2, 4'h0, 16'h0000);
        check("ack_vec", h_rdata, irq_vec);
        check("ack_pulses", ack_cnt, 2);
        // Grant withheld first; consumer stalled, so eight reads fill the buffer
        grant_en = 1'b0;
        dma_run(1'b1, 20);
        check("dma_valid", dma_valid, 1'b1);
        for (k = 1; k < 8; k++) dma_run(1'b1, 0);
        dma_run(1'b0, 0);
        check("dma_full", dma_valid, 1'b1);
        // Nobody drives the wire during these reads, so it floats high
        check("dma_word", dma_data, 18'h3ffff);
        host_op(2'h0, 4'h0, 16'h0000);
        check("rd_after", h_rdata, rd_regs[15:0]);
        stop_test();
    end
endmodule
